// ===== rtl/sdsp_pkg.sv
/*
 * shared constants for the datagram serial port: frame layout, status
 * header, link timing and buffer depth.
 * assumes a 100 MHz sys_clk on both ends of the link.
 */
package sdsp_pkg;
	// frame layout
	localparam int DG_W = 40; // bits per datagram
	localparam int DATA_W = 32; // payload bits
	localparam int ADDR_W = 7; // register address bits
	localparam int STAT_W = 8; // status header bits
	localparam int FLAG_BIT = 39; // write flag position
	localparam int ADDR_HI = 38; // address field top
	localparam int ADDR_LO = 32; // address field bottom
	localparam logic [7:0] WRITE_OFFSET = 8'h80; // added to address for writes
	localparam int REG_COUNT = 128; // registers behind the port
	localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000; // power-up value
	localparam logic [3:0] STAT_PAD = 4'h0; // unused header bits
	// link timing
	localparam int SYS_CLK_MHZ = 100; // system clock rate
	localparam int SCK_PERIOD_NS = 80; // serial clock period made by host
	localparam int SCK_HALF_CYC = SCK_PERIOD_NS * SYS_CLK_MHZ / 2000; // cycles per half
	localparam int CNT_W = 8; // half period counter width
	localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(SCK_HALF_CYC - 1);
	localparam logic [5:0] LAST_BIT = 6'(DG_W - 1);
	// buffering
	localparam int FIFO_DEPTH = 32; // request buffer words
endpackage : sdsp_pkg

// ===== rtl/sdsp_if.sv
/*
 * the four-wire serial link between host end and device end.
 * assumes both ends sit in one bench that instantiates this twice, as link and link_b.
 */
`timescale 1ns/1ns
`default_nettype none
interface sdsp_if;
	logic sck; // serial clock, idles high
	logic chip_select_n; // active low select
	logic mosi; // host to device data
	logic miso; // device to host data
	// documented device end
	modport dev (input sck, input chip_select_n, input mosi, output miso);
	// master end
	modport host (output sck, output chip_select_n, output mosi, input miso);
endinterface : sdsp_if
`default_nettype wire

// ===== rtl/sdsp_dev_end.sv
/*
 * device end of the datagram port: synchronises the link, shifts 40-bit
 * frames, latches commands on select release and runs a small register
 * array whose reads come back in the following frame.
 * assumes a link clock no faster than an eighth of sys_clk, host made.
 */
`timescale 1ns/1ns
`default_nettype none
module sdsp_dev_end (
	input wire logic sys_clk,
	input wire logic rst_n,
	sdsp_if.dev link,
	input wire logic [3:0] stat_flags,
	output logic cmd_valid,
	output logic cmd_write,
	output logic [sdsp_pkg::ADDR_W-1:0] cmd_addr,
	output logic [sdsp_pkg::DATA_W-1:0] cmd_data
);
	import sdsp_pkg::*;

	// port states, gray along idle, shift, execute
	typedef enum logic [1:0] {
		D_IDLE = 2'b00,
		D_SHIFT = 2'b01,
		D_EXEC = 2'b11
	} sdsp_dst_e;

	////////////////////////////////////////////////////////////////////////
	// input synchronisers

	logic [2:0] sck_s_q; // [0] metastable, [1] clean, [2] edge delay
	logic [2:0] sck_s_d;
	logic [2:0] csn_s_q; // same layout for select
	logic [2:0] csn_s_d;
	logic [1:0] sdi_s_q; // data needs no delay stage
	logic [1:0] sdi_s_d;

	// stage zero is read only by stage one
	always_comb begin
		sck_s_d = {sck_s_q[1:0], link.sck};
		csn_s_d = {csn_s_q[1:0], link.chip_select_n};
		sdi_s_d = {sdi_s_q[0], link.mosi};
	end

	// idle levels: clock high and select high, so no false edge at reset
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sck_s_q <= 3'h7;
			csn_s_q <= 3'h7;
			sdi_s_q <= 2'h0;
		end else begin
			sck_s_q <= sck_s_d;
			csn_s_q <= csn_s_d;
			sdi_s_q <= sdi_s_d;
		end
	end

	// edges seen on the clean stages only
	logic sck_rise;
	logic sck_fall;
	logic cs_fall;
	logic cs_rise;
	assign sck_rise = sck_s_q[1] & ~sck_s_q[2];
	assign sck_fall = ~sck_s_q[1] & sck_s_q[2];
	assign cs_fall = ~csn_s_q[1] & csn_s_q[2];
	assign cs_rise = csn_s_q[1] & ~csn_s_q[2];

	////////////////////////////////////////////////////////////////////////
	// frame engine and register array

	sdsp_dst_e state_q; // port state
	sdsp_dst_e state_d;
	logic [DG_W-1:0] sr_q; // frame shift register
	logic [DG_W-1:0] sr_d;
	logic sdo_q; // output bit, straight to the pin
	logic sdo_d;
	logic [STAT_W-1:0] stat_q; // header snapshot for next frame
	logic [STAT_W-1:0] stat_d;
	logic [DATA_W-1:0] reply_q; // payload for next frame
	logic [DATA_W-1:0] reply_d;
	logic [DATA_W-1:0] mem_q [REG_COUNT]; // registers behind the port
	logic [DATA_W-1:0] mem_d [REG_COUNT];
	logic cmd_valid_q;
	logic cmd_valid_d;
	logic cmd_write_q;
	logic cmd_write_d;
	logic [ADDR_W-1:0] cmd_addr_q;
	logic [ADDR_W-1:0] cmd_addr_d;
	logic [DATA_W-1:0] cmd_data_q;
	logic [DATA_W-1:0] cmd_data_d;

	// next values for the whole engine
	always_comb begin
		state_d = state_q;
		sr_d = sr_q;
		sdo_d = sdo_q;
		stat_d = stat_q;
		reply_d = reply_q;
		mem_d = mem_q;
		cmd_valid_d = 1'b0;
		cmd_write_d = cmd_write_q;
		cmd_addr_d = cmd_addr_q;
		cmd_data_d = cmd_data_q;
		case (state_q)
			D_IDLE: begin
				// clock and data ignored while deselected
				if (cs_fall) begin
					// header on top, payload below, first bit out at once
					// although in mode three a fall precedes the first rise and would drive this same bit
					sr_d = {stat_q, reply_q};
					sdo_d = stat_q[STAT_W-1];
					state_d = D_SHIFT;
				end
			end
			D_SHIFT: begin
				if (cs_rise) begin
					// whatever is in the shifter now is the last forty bits
					cmd_write_d = sr_q[FLAG_BIT];
					cmd_addr_d = sr_q[ADDR_HI:ADDR_LO];
					cmd_data_d = sr_q[DATA_W-1:0];
					stat_d = {STAT_PAD, stat_flags};
					state_d = D_EXEC;
				end else begin
					// msb enters first and leaves first
					if (sck_rise) begin
						sr_d = {sr_q[DG_W-2:0], sdi_s_q[1]};
					end
					// input seen forty rises ago reaches the pin here
					if (sck_fall) begin
						sdo_d = sr_q[DG_W-1];
					end
				end
			end
			D_EXEC: begin
				// write stores; read only selects what comes back next
				if (cmd_write_q) begin
					mem_d[cmd_addr_q] = cmd_data_q;
					reply_d = cmd_data_q;
				end else begin
					reply_d = mem_q[cmd_addr_q];
				end
				cmd_valid_d = 1'b1;
				state_d = D_IDLE;
			end
			default: begin
				state_d = D_IDLE;
			end
		endcase
	end

	// register only; whole array clears, which costs area but keeps
	// power-up reads defined
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_q <= D_IDLE;
			sr_q <= '0;
			sdo_q <= 1'b0;
			stat_q <= '0;
			reply_q <= REG_RESET;
			for (int i = 0; i < REG_COUNT; i++) begin
				mem_q[i] <= REG_RESET;
			end
			cmd_valid_q <= 1'b0;
			cmd_write_q <= 1'b0;
			cmd_addr_q <= '0;
			cmd_data_q <= '0;
		end else begin
			state_q <= state_d;
			sr_q <= sr_d;
			sdo_q <= sdo_d;
			stat_q <= stat_d;
			reply_q <= reply_d;
			mem_q <= mem_d;
			cmd_valid_q <= cmd_valid_d;
			cmd_write_q <= cmd_write_d;
			cmd_addr_q <= cmd_addr_d;
			cmd_data_q <= cmd_data_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, all from flops

	assign link.miso = sdo_q;
	assign cmd_valid = cmd_valid_q;
	assign cmd_write = cmd_write_q;
	assign cmd_addr = cmd_addr_q;
	assign cmd_data = cmd_data_q;
endmodule : sdsp_dev_end
`default_nettype wire

// ===== rtl/sdsp_host_end.sv
/*
 * master end of the datagram port: a request buffer feeding a mode three
 * frame engine that makes the serial clock by dividing sys_clk.
 * assumes the device end samples the link on its own 100 MHz clock.
 */
`timescale 1ns/1ns
`default_nettype none
module sdsp_fifo #(
	parameter int WIDTH = 40,
	parameter int DEPTH = 32
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int PW = $clog2(DEPTH); // pointer width, depth a power of two

	logic [WIDTH-1:0] mem_q [DEPTH]; // storage, no reset needed
	logic [PW-1:0] wr_q; // write pointer
	logic [PW-1:0] wr_d;
	logic [PW-1:0] rd_q; // read pointer
	logic [PW-1:0] rd_d;
	logic [PW:0] cnt_q; // words held
	logic [PW:0] cnt_d;
	logic room_q; // not full, flopped so in_ready comes straight from a flop
	logic room_d;
	logic push;
	logic pop;

	// pointer and count update
	always_comb begin
		push = in_valid & room_q;
		pop = out_ready & (cnt_q != '0);
		wr_d = push ? wr_q + 1'b1 : wr_q;
		rd_d = pop ? rd_q + 1'b1 : rd_q;
		cnt_d = cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
		room_d = (cnt_d != (PW+1)'(DEPTH));
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			room_q <= 1'b1;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
			room_q <= room_d;
		end
	end

	// storage write only
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	assign in_ready = room_q;
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
endmodule : sdsp_fifo

////////////////////////////////////////////////////////////////////////////

module sdsp_host_end (
	input wire logic sys_clk,
	input wire logic rst_n,
	sdsp_if.host link,
	input wire logic req_valid,
	input wire logic [sdsp_pkg::DG_W-1:0] req_data,
	output logic req_ready,
	output logic rsp_valid,
	output logic [sdsp_pkg::DG_W-1:0] rsp_data
);
	import sdsp_pkg::*;

	// gray along setup, low, high, hold, gap
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_SETUP = 3'b001,
		H_LOW = 3'b011,
		H_HIGH = 3'b010,
		H_HOLD = 3'b110,
		H_GAP = 3'b111
	} sdsp_hst_e;

	logic q_valid; // buffered request waiting
	logic [DG_W-1:0] q_data;
	logic q_take; // engine drains only when idle, so the buffer fills

	sdsp_fifo #(
		.WIDTH(DG_W),
		.DEPTH(FIFO_DEPTH)
	) u_req_fifo (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.in_valid(req_valid),
		.in_data(req_data),
		.in_ready(req_ready),
		.out_valid(q_valid),
		.out_data(q_data),
		.out_ready(q_take)
	);

	////////////////////////////////////////////////////////////////////////
	// miso synchroniser

	logic [1:0] miso_s_q; // [0] read only by [1]
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			miso_s_q <= 2'h0;
		end else begin
			miso_s_q <= {miso_s_q[0], link.miso};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// frame engine

	sdsp_hst_e state_q;
	sdsp_hst_e state_d;
	logic [CNT_W-1:0] cnt_q; // cycles within a half period
	logic [CNT_W-1:0] cnt_d;
	logic [5:0] bit_q; // bits done in this frame
	logic [5:0] bit_d;
	logic [DG_W-1:0] tx_q; // outgoing frame
	logic [DG_W-1:0] tx_d;
	logic [DG_W-1:0] rx_q; // incoming frame
	logic [DG_W-1:0] rx_d;
	logic sck_q, sck_d; // serial clock, idles high
	logic csn_q, csn_d;
	logic mosi_q, mosi_d;
	logic rsp_valid_q, rsp_valid_d;
	logic half_done;

	assign half_done = (cnt_q == HALF_LAST);
	assign q_take = (state_q == H_IDLE);

	// next values; every phase but idle lasts one half period
	always_comb begin
		state_d = state_q;
		cnt_d = half_done ? '0 : cnt_q + 1'b1;
		bit_d = bit_q;
		tx_d = tx_q;
		rx_d = rx_q;
		sck_d = sck_q;
		csn_d = csn_q;
		mosi_d = mosi_q;
		rsp_valid_d = 1'b0;
		case (state_q)
			H_IDLE: begin
				cnt_d = '0;
				if (q_valid) begin
					tx_d = q_data;
					bit_d = '0;
					csn_d = 1'b0;
					mosi_d = q_data[DG_W-1];
					state_d = H_SETUP;
				end
			end
			H_SETUP: begin
				if (half_done) begin
					sck_d = 1'b0;
					state_d = H_LOW;
				end
			end
			H_LOW: begin
				if (half_done) begin
					sck_d = 1'b1;
					state_d = H_HIGH;
				end
			end
			H_HIGH: begin
				// sample late in the high phase: the device answers through
				// its own synchroniser, so the pin settles a few cycles late
				if (half_done) begin
					rx_d = {rx_q[DG_W-2:0], miso_s_q[1]};
					tx_d = {tx_q[DG_W-2:0], 1'b0};
					bit_d = bit_q + 1'b1;
					if (bit_q == LAST_BIT) begin
						state_d = H_HOLD;
					end else begin
						sck_d = 1'b0;
						mosi_d = tx_q[DG_W-2];
						state_d = H_LOW;
					end
				end
			end
			H_HOLD: begin
				if (half_done) begin
					csn_d = 1'b1;
					rsp_valid_d = 1'b1;
					state_d = H_GAP;
				end
			end
			H_GAP: begin
				// high time lets the device latch and execute
				if (half_done) begin
					state_d = H_IDLE;
				end
			end
			default: begin
				state_d = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_q <= H_IDLE;
			cnt_q <= '0;
			bit_q <= '0;
			tx_q <= '0;
			rx_q <= '0;
			sck_q <= 1'b1;
			csn_q <= 1'b1;
			mosi_q <= 1'b0;
			rsp_valid_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			bit_q <= bit_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
			sck_q <= sck_d;
			csn_q <= csn_d;
			mosi_q <= mosi_d;
			rsp_valid_q <= rsp_valid_d;
		end
	end

	// divider gives 80 ns, well under half of sys_clk with margin
	assign link.sck = sck_q;
	assign link.chip_select_n = csn_q;
	assign link.mosi = mosi_q;
	assign rsp_valid = rsp_valid_q;
	assign rsp_data = rx_q;
endmodule : sdsp_host_end
`default_nettype wire

// ===== tb/sdsp_link_sva.sv
/*
 * link checker: watches the four wires between host end and device end.
 * assumes the host end makes an 8-cycle serial clock and 40-bit frames.
 */
`timescale 1ns/1ns
`default_nettype none
module sdsp_link_sva (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic sck,
	input wire logic chip_select_n,
	input wire logic mosi,
	input wire logic miso
);
	import sdsp_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	logic sck_q; // serial clock one cycle back
	logic [5:0] rise_q; // serial clock rises this frame
	logic [5:0] rise_d;
	////////////////////////////////////////////////////////////////////////
	// count rises while selected, cleared between frames
	always_comb begin
		rise_d = rise_q;
		if (!rst_n || chip_select_n) begin
			rise_d = '0;
		end else if (sck && !sck_q) begin
			rise_d = rise_q + 6'h1;
		end
	end
	always_ff @(posedge sys_clk) begin
		sck_q <= sck;
		rise_q <= rise_d;
	end
	////////////////////////////////////////////////////////////////////////
	idle_clock_high_a: assert property (chip_select_n |-> sck)
		else $error("serial clock low while deselected");
	frame_start_a: assert property ($fell(chip_select_n) |-> sck [*4] ##1 !sck)
		else $error("first clock fall too soon after select");
	high_phase_a: assert property ($rose(sck) |-> sck [*4])
		else $error("serial clock high phase too short");
	low_phase_a: assert property ($fell(sck) |-> !sck [*4] ##1 sck)
		else $error("serial clock low phase wrong");
	mosi_stable_a: assert property (!chip_select_n && $past(!chip_select_n) && sck
		&& $past(sck) |-> $stable(mosi))
		else $error("data moved during clock high");
	mosi_on_fall_a: assert property (!chip_select_n && $changed(mosi)
		|-> $fell(sck) || $fell(chip_select_n))
		else $error("data changed off a falling clock");
	miso_on_fall_a: assert property ($changed(miso) |-> !sck || (!chip_select_n
		&& ($past(chip_select_n, 3) || $past(chip_select_n, 4))))
		else $error("reply bit changed during clock high");
	frame_count_a: assert property ($rose(chip_select_n) |-> rise_q == 6'(DG_W))
		else $error("frame did not carry forty clocks");
	last_hold_a: assert property (!chip_select_n && rise_q == 6'(DG_W) |-> sck)
		else $error("clock moved after the last bit");
	select_gap_a: assert property ($rose(chip_select_n) |-> chip_select_n [*5])
		else $error("select high gap too short");
	// main scenarios
	cover property ($rose(chip_select_n));
	cover property (!chip_select_n && $changed(miso));
	cover property (!chip_select_n && rise_q == 6'(DG_W));
endmodule : sdsp_link_sva
`default_nettype wire

// ===== tb/test_spi_datagram_slave_port.sv
/*
 * bench: host end and device end face each other; a second device end
 * is driven by a bench-made 80 ns link clock with surplus bits.
 * assumes the package constants and the hand-over timing.
 */
`timescale 1ns/1ns
`default_nettype none
module test_spi_datagram_slave_port;
	import sdsp_pkg::*;
	localparam int NBURST = 34; // two beyond the buffer depth
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] stat_flags = 4'h0;
	logic req_valid = 1'b0;
	logic [DG_W-1:0] req_data = '0;
	logic req_ready, rsp_valid, cmd_valid, cmd_write, cmd_write_b, cmd_valid_b;
	logic [DG_W-1:0] rsp_data;
	logic [ADDR_W-1:0] cmd_addr, cmd_addr_b;
	logic [DATA_W-1:0] cmd_data, cmd_data_b;
	logic [DG_W-1:0] rsp_q[$], cmd_q[$], sent[$];
	logic [43:0] got;
	int mismatches = 0;
	int samples_checked = 0;
	int refused = 0;
	int cmds_b = 0; // commands executed by the chained device end
	sdsp_if link();
	sdsp_if link_b();
	always #5 sys_clk = ~sys_clk;
	sdsp_host_end u_sdsp_host_end (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
		.req_valid(req_valid), .req_data(req_data), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data));
	sdsp_dev_end u_sdsp_dev_end (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
		.stat_flags(stat_flags), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_addr(cmd_addr), .cmd_data(cmd_data));
	sdsp_dev_end u_sdsp_dev_end_b (.sys_clk(sys_clk), .rst_n(rst_n), .link(link_b),
		.stat_flags(stat_flags), .cmd_valid(cmd_valid_b), .cmd_write(cmd_write_b),
		.cmd_addr(cmd_addr_b), .cmd_data(cmd_data_b));
	sdsp_link_sva u_sdsp_link_sva (.sys_clk(sys_clk), .rst_n(rst_n), .sck(link.sck),
		.chip_select_n(link.chip_select_n), .mosi(link.mosi), .miso(link.miso));
	////////////////////////////////////////////////////////////////////////
	// collect pulses at the falling edge, away from register updates
	always @(negedge sys_clk) begin
		if (rsp_valid === 1'b1) rsp_q.push_back(rsp_data);
		if (cmd_valid === 1'b1) cmd_q.push_back({cmd_write, cmd_addr, cmd_data});
		if (req_valid === 1'b1 && req_ready !== 1'b1) refused++;
		if (cmd_valid_b === 1'b1) cmds_b++;
	end
	task automatic check(input string what, input logic [DG_W-1:0] seen,
		input logic [DG_W-1:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// offer one word and hold it until taken; caller drops valid
	task automatic send(input logic [DG_W-1:0] word);
		req_valid = 1'b1;
		req_data = word;
		sent.push_back(word);
		@(negedge sys_clk);
		while (req_ready !== 1'b1) @(negedge sys_clk);
		@(posedge sys_clk);
		#1;
	endtask : send
	task automatic wait_all(input int n);
		int t;
		t = 0;
		while ((rsp_q.size() < n || cmd_q.size() < n) && t < 30000) begin
			t++;
			@(negedge sys_clk);
		end
		// a hang counts as a failure and ends the run here
		if (t >= 30000) begin
			mismatches++;
			give_verdict();
		end else begin
			@(posedge sys_clk);
			#1;
		end
	endtask : wait_all
	function automatic logic [DATA_W-1:0] pay(input int k);
		return 32'ha5a5_0000 + DATA_W'(k);
	endfunction : pay
	// bench-made frame; clock toggled while deselected must be ignored
	task automatic chain_frame(input logic [43:0] w);
		repeat (5) begin
			#40 link_b.sck = 1'b0;
			link_b.mosi = ~link_b.mosi;
			#40 link_b.sck = 1'b1;
		end
		#40 link_b.chip_select_n = 1'b0;
		for (int i = 43; i >= 0; i--) begin
			#40 link_b.sck = 1'b0;
			link_b.mosi = w[i];
			// take the reply bit just before the rise, keeping an 80 ns period
			#35 got[i] = link_b.miso;
			#5 link_b.sck = 1'b1;
		end
		#40 link_b.chip_select_n = 1'b1;
		link_b.mosi = ~link_b.mosi;
	endtask : chain_frame
	task automatic give_verdict;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : give_verdict
	////////////////////////////////////////////////////////////////////////
	// watchdog, about three times the expected run
	initial begin
		#400000;
		mismatches++;
		give_verdict();
	end
	initial begin
		link_b.sck = 1'b1;
		link_b.chip_select_n = 1'b1;
		link_b.mosi = 1'b0;
		repeat (16) @(posedge sys_clk);
		#1 rst_n = 1'b1;
		check("reply", rsp_data, '0);
		check("command", {cmd_write, cmd_addr, cmd_data}, '0);
		$display("test reset done");
		// writes back to back until the buffer refuses
		stat_flags = 4'h9;
		for (int k = 0; k < NBURST; k++) send({WRITE_OFFSET + 8'(k), pay(k)});
		req_valid = 1'b0;
		wait_all(NBURST);
		check("refusals", DG_W'(refused > 0), 40'h1);
		for (int k = 0; k < NBURST; k++) check("command", cmd_q[k], sent[k]);
		for (int k = 1; k < NBURST; k++) check("echo", rsp_q[k], {8'h09, pay(k - 1)});
		check("first reply", rsp_q[0], '0);
		$display("test write burst done");
		// pipelined reads with a new status
		stat_flags = 4'h6;
		send({1'b0, 7'h03, 32'h0});
		send({1'b0, 7'h21, 32'h0});
		send({1'b0, 7'h00, 32'h0});
		req_valid = 1'b0;
		wait_all(NBURST + 3);
		check("read command", cmd_q[NBURST], {1'b0, 7'h03, 32'h0});
		check("last echo", rsp_q[NBURST], {8'h09, pay(NBURST - 1)});
		check("read reg 3", rsp_q[NBURST + 1], {8'h06, pay(3)});
		check("read reg 33", rsp_q[NBURST + 2], {8'h06, pay(33)});
		$display("test reads done");
		// 44 clocks into the second device end
		chain_frame(44'hb_c312_3456_78);
		repeat (10) @(posedge sys_clk);
		check("surplus out", DG_W'(got), 40'h0b);
		check("last forty", {cmd_write_b, cmd_addr_b, cmd_data_b}, 40'hc3_1234_5678);
		check("chain commands", DG_W'(cmds_b), 40'h1);
		$display("test chain done");
		give_verdict();
	end
endmodule : test_spi_datagram_slave_port
`default_nettype wire
